// [logic/smr_status_regs.sv]
/*
  Supply monitor status registers: live and per-cycle snapshot of status, current and voltage,
  cyclic reads by frame offset, acyclic reads by register number, and the four lamps.
  Assumes the bus controller logic shares MCLK and gives one-cycle read strobes; converter
  words and the overload pin arrive from outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module smr_status_regs #(
  parameter int unsigned MIN_CYCLE_CLKS = smr_pkg::MIN_CYCLE_CLKS,
  parameter int unsigned IO_UPDATE_CLKS = smr_pkg::IO_UPDATE_CLKS,
  parameter int unsigned LINK_TIMEOUT_CLKS = smr_pkg::LINK_TIMEOUT_CLKS,
  parameter int unsigned LED_TICK_CLKS = smr_pkg::LED_TICK_CLKS
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic MEAS_TOGGLE,
  input wire logic [15:0] MEAS_CURRENT,
  input wire logic [15:0] MEAS_BUS_V,
  input wire logic [15:0] MEAS_IO_V,
  input wire logic BUS_SUPPLY_OVLD,
  input wire logic [7:0] FUNC_MODEL,
  input wire logic [2:0] RUN_MODE,
  input wire logic CYC_FRAME,
  input wire logic CYC_RD,
  input wire logic [7:0] CYC_OFFSET,
  output logic [7:0] CYC_DATA,
  output logic CYC_DATA_VALID,
  output logic CYC_MISS,
  input wire logic ACY_RD,
  input wire logic [7:0] ACY_REG,
  output logic [15:0] ACY_DATA,
  output logic ACY_VALID,
  output logic ACY_ERR,
  output logic CYCLE_TOO_FAST,
  output logic IO_UPDATE_EACH,
  output logic [3:0] ANALOG_SLOT_COUNT,
  output logic LED_RUN_GREEN,
  output logic LED_ERR_RED,
  output logic LED_LINK_ORANGE,
  output logic LED_OVLD_RED
);

  // measurement capture and warning levels
  smr_pkg::smr_meas_s meas_in;
  smr_pkg::smr_meas_s meas;
  logic bus_warn;
  logic bus_v_low;
  logic io_low;
  logic ovld;

  assign meas_in.current = MEAS_CURRENT;
  assign meas_in.bus_v = MEAS_BUS_V;
  assign meas_in.io_v = MEAS_IO_V;

  smr_meas_sync u_meas (
    .clk(MCLK),
    .rst_n(RESETN),
    .meas_toggle(MEAS_TOGGLE),
    .meas_in(meas_in),
    .ovld_pin(BUS_SUPPLY_OVLD),
    .meas(meas),
    .bus_warn(bus_warn),
    .bus_v_low(bus_v_low),
    .io_low(io_low),
    .ovld(ovld)
  );

  // lamp timing
  logic blink;
  logic single_flash;
  logic double_flash;

  smr_led_timer #(
    .TICK_CLKS(LED_TICK_CLKS)
  ) u_led (
    .clk(MCLK),
    .rst_n(RESETN),
    .blink(blink),
    .single_flash(single_flash),
    .double_flash(double_flash)
  );

  // live register image
  smr_pkg::smr_regs_s live;
  wire logic [15:0] status_word;

  // only bits 0 and 2 can ever be set
  assign status_word = smr_pkg::STATUS_CLEAR
                     | (16'(bus_warn) << smr_pkg::STAT_BUS_WARN_BIT) // [R5] [R16]
                     | (16'(io_low) << smr_pkg::STAT_IO_LOW_BIT); // [R6] [R16]
  assign live.status = status_word;
  assign live.current = meas.current; // [R10]
  assign live.voltage = meas.bus_v; // [R11]

  // any code other than the bus controller model falls back to the standard one
  wire logic wide = FUNC_MODEL == smr_pkg::FM_BUS_CTRL; // [R9]

  // per-cycle snapshot keeps one frame coherent while the converter moves on
  smr_pkg::smr_regs_s snap_q;
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      snap_q <= '0;
    end else if (CYC_FRAME) begin
      snap_q <= live; // [R13]
    end
  end

  // cyclic offset decode
  wire logic std_hit = (CYC_OFFSET == smr_pkg::OFS_STD_STATUS)
                     || (CYC_OFFSET == smr_pkg::OFS_STD_CURRENT)
                     || (CYC_OFFSET == smr_pkg::OFS_STD_VOLTAGE);
  // fixed offsets 1,2,3 map onto register numbers 0,2,4
  wire logic [7:0] std_reg = (CYC_OFFSET == smr_pkg::OFS_STD_STATUS) ? smr_pkg::REG_STATUS :
                             (CYC_OFFSET == smr_pkg::OFS_STD_CURRENT) ? smr_pkg::REG_CURRENT :
                             smr_pkg::REG_VOLTAGE; // [R7]
  // bus controller: even byte is low half, odd byte the high half
  wire logic [7:0] bc_reg = CYC_OFFSET & smr_pkg::BYTE_POS_MASK; // [R9]
  wire logic [7:0] cyc_reg = wide ? bc_reg : std_reg;
  wire logic [16:0] cyc_word = smr_pkg::smr_reg_read(snap_q, cyc_reg, wide);
  wire logic cyc_hit = cyc_word[16] && (wide || std_hit);
  wire logic [7:0] cyc_byte = (wide && CYC_OFFSET[0]) ? cyc_word[15:8] : cyc_word[7:0];

  logic [7:0] cyc_data_q;
  logic cyc_valid_q;
  logic cyc_miss_q;
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      cyc_data_q <= 8'h00;
      cyc_valid_q <= 1'b0;
      cyc_miss_q <= 1'b0;
    end else begin
      cyc_valid_q <= CYC_RD;
      cyc_miss_q <= CYC_RD && !cyc_hit;
      if (CYC_RD) cyc_data_q <= cyc_hit ? cyc_byte : 8'h00;
    end
  end

  // acyclic: straight by register number, always the live values
  wire logic [16:0] acy_word = smr_pkg::smr_reg_read(live, ACY_REG, wide); // [R8]

  logic [15:0] acy_data_q;
  logic acy_valid_q;
  logic acy_err_q;
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      acy_data_q <= 16'h0000;
      acy_valid_q <= 1'b0;
      acy_err_q <= 1'b0;
    end else begin
      acy_valid_q <= ACY_RD;
      acy_err_q <= ACY_RD && !acy_word[16];
      if (ACY_RD) acy_data_q <= acy_word[16] ? acy_word[15:0] : 16'h0000;
    end
  end

  // bus cycle period watch
  logic [31:0] period_q;
  logic seen_frame_q;
  logic too_fast_q;
  logic io_each_q;
  wire logic [31:0] period_next = (period_q == 32'hFFFFFFFF) ? period_q : period_q + 32'h00000001;
  wire logic [31:0] period_meas = period_q + 32'h00000001;

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      period_q <= 32'h00000000;
      seen_frame_q <= 1'b0;
      too_fast_q <= 1'b0;
      io_each_q <= 1'b0;
    end else if (CYC_FRAME) begin
      period_q <= 32'h00000000;
      seen_frame_q <= 1'b1;
      if (seen_frame_q) begin
        // flags a master that breaks the shortest allowed cycle
        too_fast_q <= period_meas < 32'(MIN_CYCLE_CLKS); // [R12]
        io_each_q <= period_meas >= 32'(IO_UPDATE_CLKS); // [R13]
      end
    end else begin
      period_q <= period_next;
    end
  end

  // link activity: frames within the timeout count as running communication
  wire logic link_running = seen_frame_q && (period_q < 32'(LINK_TIMEOUT_CLKS)); // [R3]

  // lamp selection
  logic green_d;
  always_comb begin
    unique case (RUN_MODE)
      smr_pkg::SMR_MODE_RESET: green_d = single_flash; // [R15]
      smr_pkg::SMR_MODE_PRE_RUN: green_d = blink; // [R15]
      smr_pkg::SMR_MODE_RUN: green_d = 1'b1; // [R15]
      default: green_d = 1'b0;
    endcase
  end

  wire logic err_d = (io_low || bus_v_low) ? double_flash : 1'b0; // [R1] [R2]

  logic led_run_q;
  logic led_err_q;
  logic led_link_q;
  logic led_ovld_q;
  logic [3:0] slots_q;
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      // all lamps dark while held in reset, as when unpowered
      led_run_q <= 1'b0; // [R15]
      led_err_q <= 1'b0; // [R2]
      led_link_q <= 1'b0;
      led_ovld_q <= 1'b0;
      slots_q <= 4'h0;
    end else begin
      led_run_q <= green_d;
      led_err_q <= err_d;
      led_link_q <= link_running; // [R3]
      led_ovld_q <= ovld; // [R4]
      slots_q <= smr_pkg::ANALOG_SLOTS; // [R14]
    end
  end

  assign CYC_DATA = cyc_data_q;
  assign CYC_DATA_VALID = cyc_valid_q;
  assign CYC_MISS = cyc_miss_q;
  assign ACY_DATA = acy_data_q;
  assign ACY_VALID = acy_valid_q;
  assign ACY_ERR = acy_err_q;
  assign CYCLE_TOO_FAST = too_fast_q;
  assign IO_UPDATE_EACH = io_each_q;
  assign ANALOG_SLOT_COUNT = slots_q;
  assign LED_RUN_GREEN = led_run_q;
  assign LED_ERR_RED = led_err_q;
  assign LED_LINK_ORANGE = led_link_q;
  assign LED_OVLD_RED = led_ovld_q;

endmodule : smr_status_regs
`default_nettype wire

// [logic/smr_pkg.sv]
/*
  Constants, types and shared decode for the supply monitor status registers.
  Assumes one 100 MHz clock; the reader of cyclic and acyclic data lives on the same clock.
*/
//
// Function
// [R1] the red error lamp double-flashes while the I/O supply or the link supply voltage is too low.
// [R2] the red error lamp is dark when nothing is wrong and while the module is unpowered or in reset.
// [R3] the orange link lamp is lit while link frames keep arriving and dark when they stop.
// [R4] the red overload lamp is lit while the relayed bus supply reports overload and dark otherwise.
// [R5] status bit 0 is set while bus supply voltage is under 18 V or its current over 0.4 A.
// [R6] status bit 2 is set while the I/O supply voltage is under 20.4 V and clear otherwise.
// [R7] in the standard model status, current and voltage sit at cyclic frame offsets 1, 2 and 3.
// [R8] acyclic reads use register numbers: status 0, current 2, voltage 4.
// [R9] in the bus controller model all three registers are 16 bits at byte positions 0, 2 and 4.
// [R10] the current register counts the bus supply current in steps of 0.01 A.
// [R11] the voltage register counts the bus supply voltage in steps of 0.1 V.
// [R12] the bus master keeps its bus cycle at 100 us or longer.
// [R13] the cyclic data are refreshed on every bus cycle of 2 ms or longer.
// [R14] on a CAN based bus controller the module takes exactly one analog logical slot.
// [R15] the green run lamp is off unpowered, single-flashes in reset, blinks pre-run, and is on in run.
// [R16] status bit 1 and all bits from bit 3 upward read as zero in both models.
`default_nettype none
package smr_pkg;

  // clock and timing figures
  localparam int CLK_KHZ = 100_000;
  localparam int MIN_CYCLE_US = 100;
  localparam int IO_UPDATE_MS = 2;
  localparam int LED_TICK_MS = 200;
  localparam int LINK_TIMEOUT_MS = 10;
  // least times round up, all divide exactly here
  localparam int MIN_CYCLE_CLKS = (MIN_CYCLE_US * CLK_KHZ + 999) / 1000;
  localparam int IO_UPDATE_CLKS = IO_UPDATE_MS * CLK_KHZ;
  localparam int LED_TICK_CLKS = LED_TICK_MS * CLK_KHZ;
  localparam int LINK_TIMEOUT_CLKS = LINK_TIMEOUT_MS * CLK_KHZ;

  // function model codes
  localparam logic [7:0] FM_STANDARD = 8'h00;
  localparam logic [7:0] FM_BUS_CTRL = 8'hFE;

  // register numbers (acyclic) and bus controller byte positions
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CURRENT = 8'h02;
  localparam logic [7:0] REG_VOLTAGE = 8'h04;
  // standard model fixed cyclic offsets
  localparam logic [7:0] OFS_STD_STATUS = 8'h01;
  localparam logic [7:0] OFS_STD_CURRENT = 8'h02;
  localparam logic [7:0] OFS_STD_VOLTAGE = 8'h03;
  localparam logic [7:0] BYTE_POS_MASK = 8'hFE;

  // status bit layout
  localparam int STAT_BUS_WARN_BIT = 0;
  localparam int STAT_IO_LOW_BIT = 2;
  localparam logic [15:0] STATUS_CLEAR = 16'h0000;

  // thresholds in register counts (0.1 V and 0.01 A steps)
  localparam logic [15:0] BUS_V_MIN_DV = 16'h00B4;
  localparam logic [15:0] BUS_I_MAX_CA = 16'h0028;
  localparam logic [15:0] IO_V_MIN_DV = 16'h00CC;
  localparam logic [15:0] BYTE_MAX = 16'h00FF;

  localparam logic [3:0] ANALOG_SLOTS = 4'h1;

  typedef enum logic [2:0] {
    SMR_MODE_RESET = 3'h1,
    SMR_MODE_PRE_RUN = 3'h2,
    SMR_MODE_RUN = 3'h4
  } smr_mode_e;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] bus_v;
    logic [15:0] io_v;
  } smr_meas_s;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] current;
    logic [15:0] voltage;
  } smr_regs_s;

  // returns {hit, value}; narrow model saturates to one byte
  function automatic logic [16:0] smr_reg_read(input smr_regs_s regs, input logic [7:0] regnum,
                                               input logic wide);
    logic [15:0] w;
    logic hit;
    w = 16'h0000;
    hit = 1'b1;
    if (regnum == REG_STATUS) begin
      w = regs.status;
    end else if (regnum == REG_CURRENT) begin
      w = regs.current;
    end else if (regnum == REG_VOLTAGE) begin
      w = regs.voltage;
    end else begin
      hit = 1'b0;
    end
    if (!wide && (w > BYTE_MAX)) begin
      w = BYTE_MAX;
    end
    return {hit, w};
  endfunction : smr_reg_read

endpackage : smr_pkg
`default_nettype wire

// [logic/smr_meas_sync.sv]
/*
  Measurement capture: brings converter words and the overload pin into the clock domain and
  derives the warning levels. Assumes the converter holds its words steady across a toggle.
*/
`timescale 1ns/100ps
`default_nettype none
module smr_meas_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic meas_toggle,
  input wire smr_pkg::smr_meas_s meas_in,
  input wire logic ovld_pin,
  output smr_pkg::smr_meas_s meas,
  output logic bus_warn,
  output logic bus_v_low,
  output logic io_low,
  output logic ovld
);
  logic tog_s1_q, tog_s2_q, tog_s3_q;
  logic ovld_s1_q, ovld_s2_q;
  smr_pkg::smr_meas_s data_s1_q, data_s2_q, meas_q;
  wire logic new_sample = tog_s2_q ^ tog_s3_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      ovld_s1_q <= 1'b0;
      ovld_s2_q <= 1'b0;
      data_s1_q <= '0;
      data_s2_q <= '0;
      meas_q <= '0;
    end else begin
      tog_s1_q <= meas_toggle;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      ovld_s1_q <= ovld_pin;
      ovld_s2_q <= ovld_s1_q;
      data_s1_q <= meas_in;
      data_s2_q <= data_s1_q;
      // words only taken after the toggle has settled, so they are stable
      if (new_sample) meas_q <= data_s2_q;
    end
  end

  assign meas = meas_q;
  assign bus_v_low = meas_q.bus_v < smr_pkg::BUS_V_MIN_DV;
  assign bus_warn = bus_v_low || (meas_q.current > smr_pkg::BUS_I_MAX_CA); // [R5]
  assign io_low = meas_q.io_v < smr_pkg::IO_V_MIN_DV; // [R6]
  assign ovld = ovld_s2_q;
endmodule : smr_meas_sync
`default_nettype wire

// [logic/smr_led_timer.sv]
/*
  Lamp timing base: one shared phase counter gives blink, single and double flash levels.
  Assumes the lamp drivers register these levels themselves.
*/
`timescale 1ns/100ps
`default_nettype none
module smr_led_timer #(
  parameter int unsigned TICK_CLKS = smr_pkg::LED_TICK_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic blink,
  output logic single_flash,
  output logic double_flash
);
  logic [31:0] tick_q;
  logic [2:0] phase_q;
  wire logic tick_end = tick_q >= 32'(TICK_CLKS - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_q <= 32'h00000000;
      phase_q <= 3'h0;
    end else if (tick_end) begin
      tick_q <= 32'h00000000;
      phase_q <= phase_q + 3'h1;
    end else begin
      tick_q <= tick_q + 32'h00000001;
    end
  end

  // eight ticks per pattern: single lights tick 0, double ticks 0 and 2
  assign blink = ~phase_q[0];
  assign single_flash = phase_q == 3'h0;
  assign double_flash = (phase_q == 3'h0) || (phase_q == 3'h2);
endmodule : smr_led_timer
`default_nettype wire

// [sim/smr_status_regs_assertions.sv]
/* Port checker for smr_status_regs: read answers, offset maps, link and overload lamps, slot count.
   Assumes it is bound to the top instance and shares MCLK and RESETN with it. */
`timescale 1ns/100ps
`default_nettype none
module smr_status_regs_assertions (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic BUS_SUPPLY_OVLD,
  input wire logic [7:0] FUNC_MODEL,
  input wire logic CYC_FRAME,
  input wire logic CYC_RD,
  input wire logic [7:0] CYC_OFFSET,
  input wire logic [7:0] CYC_DATA,
  input wire logic CYC_DATA_VALID,
  input wire logic CYC_MISS,
  input wire logic ACY_RD,
  input wire logic [7:0] ACY_REG,
  input wire logic [15:0] ACY_DATA,
  input wire logic ACY_VALID,
  input wire logic ACY_ERR,
  input wire logic [3:0] ANALOG_SLOT_COUNT,
  input wire logic LED_LINK_ORANGE,
  input wire logic LED_OVLD_RED
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  wire logic wide = (FUNC_MODEL == 8'hFE);
  wire logic acy_hit = (ACY_REG == 8'h00) || (ACY_REG == 8'h02) || (ACY_REG == 8'h04);
  wire logic cyc_hit = wide ? (CYC_OFFSET <= 8'h05) : ((CYC_OFFSET >= 8'h01) && (CYC_OFFSET <= 8'h03));
  a_acy_answer_flags: assert property (ACY_RD |=> ACY_VALID && (ACY_ERR == !$past(acy_hit)))
    else $error("acyclic answer or error flag wrong");
  a_acy_err_zero: assert property (ACY_RD && !acy_hit |=> ACY_DATA == 16'h0000)
    else $error("unknown register returned data");
  a_status_reserved: assert property (ACY_RD && ACY_REG == 8'h00 |=> (ACY_DATA & 16'hFFFA) == 16'h0000)
    else $error("reserved status bit set");
  a_std_narrow: assert property (ACY_RD && !wide |=> ACY_DATA[15:8] == 8'h00)
    else $error("standard model value wider than a byte");
  a_cyc_offset_map: assert property (CYC_RD |=> CYC_DATA_VALID && (CYC_MISS != $past(cyc_hit)))
    else $error("cyclic offset map wrong");
  a_cyc_miss_zero: assert property (CYC_RD && !cyc_hit |=> CYC_DATA == 8'h00)
    else $error("missed cyclic offset returned data");
  a_link_after_frame: assert property (CYC_FRAME |-> ##2 LED_LINK_ORANGE)
    else $error("link lamp dark after frame");
  a_ovld_lamp_on: assert property (BUS_SUPPLY_OVLD [*8] |-> LED_OVLD_RED)
    else $error("overload lamp dark during overload");
  a_ovld_lamp_off: assert property (!BUS_SUPPLY_OVLD [*8] |-> !LED_OVLD_RED)
    else $error("overload lamp lit without overload");
  a_slot_count: assert property ($past(RESETN) |-> ANALOG_SLOT_COUNT == 4'h1)
    else $error("analog slot count not one");
endmodule : smr_status_regs_assertions
`default_nettype wire

// [sim/smr_bus_ctrl_model.sv]
/* Bus controller model: frame pulses and one-cycle cyclic and acyclic reads.
   Assumes the testbench calls its tasks; all changes land on falling clock edges. */
`timescale 1ns/100ps
`default_nettype none
module smr_bus_ctrl_model (
  input wire logic clk,
  output logic cyc_frame,
  output logic cyc_rd,
  output logic [7:0] cyc_offset,
  input wire logic [7:0] cyc_data,
  input wire logic cyc_valid,
  input wire logic cyc_miss,
  output logic acy_rd,
  output logic [7:0] acy_reg,
  input wire logic [15:0] acy_data,
  input wire logic acy_valid,
  input wire logic acy_err
);
  initial begin
    {cyc_frame, cyc_rd, acy_rd} = 3'h0;
    cyc_offset = 8'hA5;
    acy_reg = 8'h5A;
  end
  // caller picks the gap; only the too-fast scenario goes below the minimum
  task automatic frame(input int gap);
    repeat (gap) @(negedge clk);
    cyc_frame = 1'b1;
    @(negedge clk);
    cyc_frame = 1'b0;
  endtask : frame
  // released address is inverted so a stale value cannot pass for a held one
  task automatic cyc_read(input logic [7:0] ofs, output logic [7:0] d, output logic v, output logic m);
    @(negedge clk);
    cyc_rd = 1'b1;
    cyc_offset = ofs;
    @(negedge clk);
    d = cyc_data;
    v = cyc_valid;
    m = cyc_miss;
    cyc_rd = 1'b0;
    cyc_offset = ~ofs;
  endtask : cyc_read
  task automatic acy_read(input logic [7:0] rn, output logic [15:0] d, output logic v, output logic m);
    @(negedge clk);
    acy_rd = 1'b1;
    acy_reg = rn;
    @(negedge clk);
    d = acy_data;
    v = acy_valid;
    m = acy_err;
    acy_rd = 1'b0;
    acy_reg = ~rn;
  endtask : acy_read
endmodule : smr_bus_ctrl_model
`default_nettype wire

// [sim/smr_status_regs_tb_top.sv]
/* Testbench top for smr_status_regs with the bus controller model and checker.
   Assumes shortened count parameters; inputs change on falling MCLK edges. */
`timescale 1ns/100ps
`default_nettype none
module smr_status_regs_tb_top;
  logic MCLK, RESETN, MEAS_TOGGLE, BUS_SUPPLY_OVLD;
  logic [15:0] MEAS_CURRENT, MEAS_BUS_V, MEAS_IO_V, ACY_DATA;
  logic [7:0] FUNC_MODEL, CYC_OFFSET, ACY_REG, CYC_DATA;
  logic [2:0] RUN_MODE;
  logic [3:0] ANALOG_SLOT_COUNT;
  logic CYC_FRAME, CYC_RD, CYC_DATA_VALID, CYC_MISS, ACY_RD, ACY_VALID, ACY_ERR, CYCLE_TOO_FAST;
  logic IO_UPDATE_EACH, LED_RUN_GREEN, LED_ERR_RED, LED_LINK_ORANGE, LED_OVLD_RED;
  int err_total = 0;
  int checks_done = 0;
  // current, bus voltage, io voltage: at each limit, then one count past it
  logic [47:0] smp [5] = '{48'h0028_00B4_00CC, 48'h0029_00B4_00CC, 48'h0028_00B3_00CC,
                           48'h0028_00B4_00CB, 48'h012C_01F4_0064};
  logic [15:0] gexp [3] = '{16'h0004, 16'h0010, 16'h0020};
  smr_status_regs #(.MIN_CYCLE_CLKS(20), .IO_UPDATE_CLKS(40), .LINK_TIMEOUT_CLKS(60), .LED_TICK_CLKS(4))
    u_smr_status_regs (.MCLK(MCLK), .RESETN(RESETN), .MEAS_TOGGLE(MEAS_TOGGLE), .MEAS_CURRENT(MEAS_CURRENT),
    .MEAS_BUS_V(MEAS_BUS_V), .MEAS_IO_V(MEAS_IO_V), .BUS_SUPPLY_OVLD(BUS_SUPPLY_OVLD), .FUNC_MODEL(FUNC_MODEL),
    .RUN_MODE(RUN_MODE), .CYC_FRAME(CYC_FRAME), .CYC_RD(CYC_RD), .CYC_OFFSET(CYC_OFFSET), .CYC_DATA(CYC_DATA),
    .CYC_DATA_VALID(CYC_DATA_VALID), .CYC_MISS(CYC_MISS), .ACY_RD(ACY_RD), .ACY_REG(ACY_REG),
    .ACY_DATA(ACY_DATA), .ACY_VALID(ACY_VALID), .ACY_ERR(ACY_ERR), .CYCLE_TOO_FAST(CYCLE_TOO_FAST),
    .IO_UPDATE_EACH(IO_UPDATE_EACH), .ANALOG_SLOT_COUNT(ANALOG_SLOT_COUNT), .LED_RUN_GREEN(LED_RUN_GREEN),
    .LED_ERR_RED(LED_ERR_RED), .LED_LINK_ORANGE(LED_LINK_ORANGE), .LED_OVLD_RED(LED_OVLD_RED));
  smr_bus_ctrl_model u_smr_bus_ctrl_model (.clk(MCLK), .cyc_frame(CYC_FRAME), .cyc_rd(CYC_RD),
    .cyc_offset(CYC_OFFSET), .cyc_data(CYC_DATA), .cyc_valid(CYC_DATA_VALID), .cyc_miss(CYC_MISS),
    .acy_rd(ACY_RD), .acy_reg(ACY_REG), .acy_data(ACY_DATA), .acy_valid(ACY_VALID), .acy_err(ACY_ERR));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  function automatic logic [15:0] sat(input logic [15:0] v, input logic wide);
    return (wide || v < 16'h0100) ? v : 16'h00FF;
  endfunction : sat
  initial begin : watchdog
    repeat (60000) @(posedge MCLK);
    err_total++;
    end_sim();
  end
  initial begin : main
    logic [15:0] v [3];
    logic [15:0] d, ex;
    logic [7:0] b;
    logic ok, bad, wide, hit;
    int g, e;
    {MEAS_TOGGLE, BUS_SUPPLY_OVLD} = 2'h0;
    // words in range but never announced, so status must still show reset counts
    {MEAS_CURRENT, MEAS_BUS_V, MEAS_IO_V} = smp[0];
    FUNC_MODEL = 8'h00;
    RUN_MODE = 3'h1;
    RESETN = 1'b0;
    repeat (4) @(negedge MCLK);
    RESETN = 1'b1;
    repeat (2) @(negedge MCLK);
    chk("slots", {12'h000, ANALOG_SLOT_COUNT}, 16'h0001);
    chk("link idle", {15'h0000, LED_LINK_ORANGE}, 16'h0000);
    u_smr_bus_ctrl_model.acy_read(8'h00, d, ok, bad);
    chk("unsampled status", d, 16'h0005);
    u_smr_bus_ctrl_model.frame(2);
    // lamp is registered behind the frame flag, one edge later
    @(negedge MCLK);
    chk("link on", {15'h0000, LED_LINK_ORANGE}, 16'h0001);
    u_smr_bus_ctrl_model.frame(8);
    @(negedge MCLK);
    chk("too fast", {14'h0000, CYCLE_TOO_FAST, IO_UPDATE_EACH}, 16'h0002);
    u_smr_bus_ctrl_model.frame(25);
    @(negedge MCLK);
    chk("mid period", {14'h0000, CYCLE_TOO_FAST, IO_UPDATE_EACH}, 16'h0000);
    u_smr_bus_ctrl_model.frame(45);
    @(negedge MCLK);
    chk("slow period", {14'h0000, CYCLE_TOO_FAST, IO_UPDATE_EACH}, 16'h0001);
    for (int k = 0; k < 5; k++) begin
      BUS_SUPPLY_OVLD = k[0];
      RUN_MODE = 3'h1 << (k % 3);
      {MEAS_CURRENT, MEAS_BUS_V, MEAS_IO_V} = smp[k];
      repeat (5) @(negedge MCLK);
      MEAS_TOGGLE = ~MEAS_TOGGLE;
      repeat (8) @(negedge MCLK);
      v[0] = {13'h0000, MEAS_IO_V < 16'h00CC, 1'b0, (MEAS_BUS_V < 16'h00B4) || (MEAS_CURRENT > 16'h0028)};
      v[1] = MEAS_CURRENT;
      v[2] = MEAS_BUS_V;
      g = 0;
      e = 0;
      // 32 cycles is one whole lamp pattern, so counts do not depend on phase
      repeat (32) begin
        @(negedge MCLK);
        g += int'(LED_RUN_GREEN);
        e += int'(LED_ERR_RED);
      end
      chk("green lamp", 16'(g), gexp[k % 3]);
      chk("error lamp", 16'(e), (v[0][2] || MEAS_BUS_V < 16'h00B4) ? 16'h0008 : 16'h0000);
      chk("overload lamp", {15'h0000, LED_OVLD_RED}, {15'h0000, BUS_SUPPLY_OVLD});
      for (int m = 0; m < 2; m++) begin
        wide = m[0];
        FUNC_MODEL = wide ? 8'hFE : 8'h00;
        @(negedge MCLK);
        for (int r = 0; r < 6; r++) begin
          u_smr_bus_ctrl_model.acy_read(8'(r), d, ok, bad);
          ex = r[0] ? 16'h0000 : sat(v[r / 2], wide);
          chk("acyclic data", d, ex);
          chk("acyclic flags", {14'h0000, ok, bad}, {14'h0000, 1'b1, r[0]});
        end
        u_smr_bus_ctrl_model.frame(25);
        for (int o = 0; o < 7; o++) begin
          hit = wide ? (o < 6) : (o > 0 && o < 4);
          ex = !hit ? 16'h0000 : wide ? (o[0] ? v[o / 2][15:8] : v[o / 2][7:0]) : sat(v[o - 1], 1'b0);
          u_smr_bus_ctrl_model.cyc_read(8'(o), b, ok, bad);
          chk("cyclic data", {8'h00, b}, ex);
          chk("cyclic flags", {14'h0000, ok, bad}, {14'h0000, 1'b1, !hit});
        end
      end
    end
    // no legal mode code: green lamp must stay dark
    RUN_MODE = 3'h3;
    repeat (80) @(negedge MCLK);
    chk("link timeout", {15'h0000, LED_LINK_ORANGE}, 16'h0000);
    chk("green no mode", {15'h0000, LED_RUN_GREEN}, 16'h0000);
    end_sim();
  end
endmodule : smr_status_regs_tb_top
bind smr_status_regs smr_status_regs_assertions u_smr_status_regs_assertions (.MCLK(MCLK), .RESETN(RESETN),
  .BUS_SUPPLY_OVLD(BUS_SUPPLY_OVLD), .FUNC_MODEL(FUNC_MODEL), .CYC_FRAME(CYC_FRAME), .CYC_RD(CYC_RD),
  .CYC_OFFSET(CYC_OFFSET), .CYC_DATA(CYC_DATA), .CYC_DATA_VALID(CYC_DATA_VALID), .CYC_MISS(CYC_MISS),
  .ACY_RD(ACY_RD), .ACY_REG(ACY_REG), .ACY_DATA(ACY_DATA), .ACY_VALID(ACY_VALID), .ACY_ERR(ACY_ERR),
  .ANALOG_SLOT_COUNT(ANALOG_SLOT_COUNT), .LED_LINK_ORANGE(LED_LINK_ORANGE), .LED_OVLD_RED(LED_OVLD_RED));
`default_nettype wire
